// file: verilog/t1_alarm_error_irq_regs.sv
// receive alarm and error interrupt registers with the out-of-frame
// detector and the persistence filters for the two alarm defects.
// assumes detector inputs come from framer logic on clock_i and a
// register master that holds each strobe for one cycle.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "t1_alarm_defs.svh"

module t1_alarm_error_irq_regs
  import t1_alarm_pkg::*;
#(
  parameter int unsigned AIS_CYCLES = `AIS_PERSIST_CYCLES,
  parameter int unsigned YEL_CYCLES = `YEL_PERSIST_CYCLES
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // framer detector side
  input wire logic frame_bit_check_i,
  input wire logic frame_bit_error_i,
  input wire logic frame_regained_i,
  input wire logic ais_cond_i,
  input wire logic rai_cond_i,
  input wire logic lcv_i,
  // results
  output logic oof_state_o,
  output logic ais_state_o,
  output logic yel_state_o,
  output logic irq_o
);

  // ============================================================
  // address decode helper
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  logic wr_status;
  logic wr_enable;
  logic wr_framing;
  logic rd_status;
  logic rd_enable;
  logic rd_framing;

  // strobes qualified by address
  assign wr_status = reg_wr_i && addr_hit(reg_addr_i, `ADDR_STATUS);
  assign wr_enable = reg_wr_i && addr_hit(reg_addr_i, `ADDR_ENABLE);
  assign wr_framing = reg_wr_i && addr_hit(reg_addr_i, `ADDR_FRAMING);
  assign rd_status = reg_rd_i && addr_hit(reg_addr_i, `ADDR_STATUS);
  assign rd_enable = reg_rd_i && addr_hit(reg_addr_i, `ADDR_ENABLE);
  assign rd_framing = reg_rd_i && addr_hit(reg_addr_i, `ADDR_FRAMING);

  // ============================================================
  // enable and framing control registers
  reg_byte_t alarm_error_irq_enable;
  reg_byte_t framing_ctrl;
  reg_byte_t next_enable;
  logic [`FIELD_W-1:0] frame_error_tolerance;
  logic [`FIELD_W-1:0] frame_error_window;

  // bits 7..5 are dropped on write so they always read zero
  assign next_enable = reg_wdata_i & `ENABLE_WR_MASK;
  assign frame_error_tolerance =
    framing_ctrl[`TOL_LSB +: `FIELD_W];
  assign frame_error_window =
    framing_ctrl[`WIN_LSB +: `FIELD_W];

  // control registers take plain writes
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alarm_error_irq_enable <= `ENABLE_RESET;
      framing_ctrl <= `FRAMING_RESET;
    end else begin
      if (wr_enable) begin
        alarm_error_irq_enable <= next_enable;
      end
      if (wr_framing) begin
        framing_ctrl <= reg_wdata_i;
      end
    end
  end

  logic line_code_error_irq_en;
  logic frame_loss_change_irq_en;
  logic alarm_indication_change_irq_en;
  logic remote_alarm_change_irq_en;

  // bit 4 is stored for readback but steers nothing; software
  // keeps it at zero
  assign line_code_error_irq_en =
    alarm_error_irq_enable[`BIT_LCV];
  assign frame_loss_change_irq_en =
    alarm_error_irq_enable[`BIT_OOF_CHG];
  assign alarm_indication_change_irq_en =
    alarm_error_irq_enable[`BIT_AIS_CHG];
  assign remote_alarm_change_irq_en =
    alarm_error_irq_enable[`BIT_YEL_CHG];

  // ============================================================
  // out-of-frame detector
  oof_state_t oof_state;
  oof_state_t next_oof_state;
  logic [`FIELD_W-1:0] err_cnt;
  logic [`FIELD_W-1:0] win_cnt;
  logic [`FIELD_W-1:0] next_err_cnt;
  logic [`FIELD_W-1:0] next_win_cnt;
  logic [`FIELD_W-1:0] err_plus;
  logic [`FIELD_W-1:0] win_plus;
  logic bad_bit;
  logic tol_hit;
  logic win_end;
  logic count_clear;

  // err_cnt stays below the tolerance, or below the window at zero tolerance, so the sum cannot wrap
  assign err_plus = `FIELD_W'(err_cnt + `FIELD_W'(1));
  assign win_plus = `FIELD_W'(win_cnt + `FIELD_W'(1));
  assign bad_bit = frame_bit_check_i && frame_bit_error_i;
  // zero tolerance disables declaration altogether
  assign tol_hit = bad_bit && (frame_error_tolerance != '0) &&
                   (err_plus >= frame_error_tolerance);
  // zero window restarts the count at every framing bit
  assign win_end = frame_bit_check_i &&
                   (win_plus >= frame_error_window);
  assign count_clear = (oof_state == OUT_OF_FRAME) ||
                       tol_hit || win_end;
  assign next_err_cnt = count_clear ? '0 :
    (bad_bit ? err_plus : err_cnt);
  assign next_win_cnt = count_clear ? '0 :
    (frame_bit_check_i ? win_plus : win_cnt);

  // declare on tolerance, clear when the framer realigns
  always_comb begin
    next_oof_state = oof_state;
    unique case (oof_state)
      IN_FRAME: begin
        if (tol_hit) begin
          next_oof_state = OUT_OF_FRAME;
        end
      end
      OUT_OF_FRAME: begin
        if (frame_regained_i) begin
          next_oof_state = IN_FRAME;
        end
      end
      default: begin
        next_oof_state = OUT_OF_FRAME;
      end
    endcase
  end

  // detector registers
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oof_state <= IN_FRAME;
      err_cnt <= '0;
      win_cnt <= '0;
    end else begin
      oof_state <= next_oof_state;
      err_cnt <= next_err_cnt;
      win_cnt <= next_win_cnt;
    end
  end

  assign oof_state_o = (oof_state == OUT_OF_FRAME);

  // ============================================================
  // alarm defect filters
  // counts of 8.4 million and 180 million cycles: a bench can shorten them
  persist_filter #(
    .SET_CYCLES(AIS_CYCLES),
    .CLR_CYCLES(AIS_CYCLES)
  ) u_ais_filter (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .cond_i(ais_cond_i),
    .state_o(ais_state_o)
  );

  // yellow clears without delay
  persist_filter #(
    .SET_CYCLES(YEL_CYCLES),
    .CLR_CYCLES(`YEL_CLEAR_CYCLES)
  ) u_yel_filter (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .cond_i(rai_cond_i),
    .state_o(yel_state_o)
  );

  // ============================================================
  // change detection
  logic oof_seen;
  logic ais_seen;
  logic yel_seen;
  logic [`FLAG_COUNT-1:0] flag_event;

  // previous defect states, for both edges
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oof_seen <= 1'b0;
      ais_seen <= 1'b0;
      yel_seen <= 1'b0;
    end else begin
      oof_seen <= oof_state_o;
      ais_seen <= ais_state_o;
      yel_seen <= yel_state_o;
    end
  end

  // declare and clear both count as a change
  assign flag_event[`BIT_OOF_CHG] = oof_state_o ^ oof_seen;
  assign flag_event[`BIT_AIS_CHG] = ais_state_o ^ ais_seen;
  assign flag_event[`BIT_YEL_CHG] = yel_state_o ^ yel_seen;
  assign flag_event[`BIT_LCV] = lcv_i;

  // ============================================================
  // sticky status flags
  logic [`FLAG_COUNT-1:0] flag;
  logic [`FLAG_COUNT-1:0] flag_clear;
  logic [`FLAG_COUNT-1:0] next_flag;

  // a read clears all flags, a write of one clears single flags
  assign flag_clear = (rd_status ? `FLAG_ALL : `STATUS_RESET) |
    (wr_status ? reg_wdata_i[`FLAG_COUNT-1:0] : `STATUS_RESET);
  // the event term goes last so a set beats a same-cycle clear
  assign next_flag = (flag & ~flag_clear) | flag_event;

  generate
    for (genvar i = 0; i < `FLAG_COUNT; i++) begin : g_flag
      // one flip-flop per flag
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          flag[i] <= 1'b0;
        end else begin
          flag[i] <= next_flag[i];
        end
      end
    end
  endgenerate

  logic frame_loss_change_flag;
  logic alarm_indication_change_flag;
  logic remote_alarm_change_flag;
  logic line_code_error_flag;

  assign frame_loss_change_flag = flag[`BIT_OOF_CHG];
  assign alarm_indication_change_flag = flag[`BIT_AIS_CHG];
  assign remote_alarm_change_flag = flag[`BIT_YEL_CHG];
  assign line_code_error_flag = flag[`BIT_LCV];

  // ============================================================
  // interrupt output
  logic [`FLAG_COUNT-1:0] live;

  assign live[`BIT_OOF_CHG] =
    frame_loss_change_flag && frame_loss_change_irq_en;
  assign live[`BIT_LCV] =
    line_code_error_flag && line_code_error_irq_en;
  assign live[`BIT_AIS_CHG] = alarm_indication_change_flag &&
    alarm_indication_change_irq_en;
  assign live[`BIT_YEL_CHG] =
    remote_alarm_change_flag && remote_alarm_change_irq_en;
  // level output, drops as soon as no enabled flag remains
  assign irq_o = |live;

  // ============================================================
  // read data
  reg_byte_t alarm_error_irq_status;
  reg_byte_t read_mux;

  assign alarm_error_irq_status = {oof_state_o, ais_state_o,
    yel_state_o, 1'b0, flag};
  // unmapped addresses read zero
  assign read_mux =
    rd_status ? alarm_error_irq_status :
    rd_enable ? alarm_error_irq_enable :
    rd_framing ? framing_ctrl : 8'h00;

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? read_mux : 8'h00;
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  a_oof_change_flag: assert property (
    (oof_state_o != $past(oof_state_o)) |=> frame_loss_change_flag)
    else $error("out-of-frame change not latched");

  a_ais_change_flag: assert property (
    $changed(ais_state_o) |=> alarm_indication_change_flag)
    else $error("alarm indication change not latched");

  a_yel_change_flag: assert property (
    $changed(yel_state_o) |=> remote_alarm_change_flag)
    else $error("yellow change not latched");

  a_read_clears_oof: assert property (
    (rd_status && !flag_event[`BIT_OOF_CHG]) |=>
      !frame_loss_change_flag)
    else $error("out-of-frame flag survived a read");

  a_oof_declare: assert property (
    (oof_state == IN_FRAME && bad_bit &&
     frame_error_tolerance != 4'h0 &&
     err_cnt == frame_error_tolerance - 4'h1) |=> oof_state_o)
    else $error("tolerance reached without out-of-frame");

  a_oof_irq_gate: assert property (
    (frame_loss_change_flag && !frame_loss_change_irq_en &&
     (flag & alarm_error_irq_enable[3:0] & 4'hb) == 4'h0) |-> !irq_o)
    else $error("masked out-of-frame raised interrupt");

  a_lcv_to_irq: assert property (
    (lcv_i && line_code_error_irq_en && !wr_enable) |=> irq_o)
    else $error("enabled violation gave no interrupt");

  a_reserved_zero: assert property (
    rd_enable |=> reg_rdata_o[7:5] == 3'h0)
    else $error("reserved enable bits read nonzero");

  a_lcv_latch: assert property (
    lcv_i |=> line_code_error_flag ##0 $past(lcv_i))
    else $error("violation not latched");

  a_yel_clear_now: assert property (
    (yel_state_o && !rai_cond_i) |=> !yel_state_o)
    else $error("yellow did not clear at once");

  a_irq_cause: assert property (
    irq_o |-> (flag & alarm_error_irq_enable[3:0]) != 4'h0)
    else $error("interrupt without an enabled flag");

  a_set_beats_read: assert property (
    (rd_status && lcv_i) |=> line_code_error_flag)
    else $error("violation lost in read cycle");

  a_ais_irq_gate: assert property (
    (alarm_indication_change_flag &&
     alarm_indication_change_irq_en) |-> irq_o)
    else $error("enabled alarm indication flag without interrupt");

endmodule
`default_nettype wire

// file: pkg/t1_alarm_defs.svh
// offsets, field positions, reset values and timing counts for the
// receive alarm and error interrupt block.
// assumes an 8-bit register port and a 200 MHz framer clock.
`ifndef T1_ALARM_DEFS_SVH
`define T1_ALARM_DEFS_SVH

// ============================================================
// register map
`define ADDR_STATUS 8'h00
`define ADDR_ENABLE 8'h01
`define ADDR_FRAMING 8'h02

// ============================================================
// status and enable fields
`define BIT_YEL_CHG 0
`define BIT_AIS_CHG 1
`define BIT_OOF_CHG 2
`define BIT_LCV 3
`define BIT_KEEP_ZERO 4
`define BIT_YEL_STATE 5
`define BIT_AIS_STATE 6
`define BIT_OOF_STATE 7
`define FLAG_COUNT 4
`define FLAG_ALL 4'hf
`define ENABLE_WR_MASK 8'h1f
`define STATUS_RESET 4'h0
`define ENABLE_RESET 8'h00
`define FRAMING_RESET 8'h00
`define TOL_LSB 0
`define WIN_LSB 4
`define FIELD_W 4

// ============================================================
// timing
`define CLOCK_KHZ 200000
`define AIS_PERSIST_MS 42
`define YEL_PERSIST_MS 900
`define YEL_CLEAR_MS 0
`define AIS_PERSIST_CYCLES (`AIS_PERSIST_MS * `CLOCK_KHZ)
`define YEL_PERSIST_CYCLES (`YEL_PERSIST_MS * `CLOCK_KHZ)
`define YEL_CLEAR_CYCLES (`YEL_CLEAR_MS * `CLOCK_KHZ)
`define PERSIST_CNT_W 28

`endif

// file: pkg/t1_alarm_pkg.sv
// types shared by the alarm and error interrupt block.
// assumes nothing beyond the defines header.
`default_nettype none
package t1_alarm_pkg;

  // ============================================================
  // frame alignment state, one-hot
  typedef enum logic [1:0] {
    IN_FRAME = 2'b01,
    OUT_OF_FRAME = 2'b10
  } oof_state_t;

  typedef logic [7:0] reg_byte_t;

endpackage
`default_nettype wire

// file: verilog/persist_filter.sv
// persistence filter: a level is declared after it has held for a set
// number of cycles and cleared after it has been absent for another.
// assumes cond_i comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "t1_alarm_defs.svh"

module persist_filter #(
  parameter int unsigned SET_CYCLES = 1,
  parameter int unsigned CLR_CYCLES = 0
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic cond_i,
  output logic state_o
);

  logic [`PERSIST_CNT_W-1:0] cnt;
  logic [`PERSIST_CNT_W-1:0] next_cnt;
  logic next_state;
  logic agree;
  logic set_done;
  logic clr_done;

  // ============================================================
  // counting runs only while the input disagrees with the state
  assign agree = (cond_i == state_o);
  assign set_done = (cnt >= `PERSIST_CNT_W'(SET_CYCLES - 1));
  // zero clear time means an immediate clear
  assign clr_done = (CLR_CYCLES == 0) ||
                    (cnt >= `PERSIST_CNT_W'(CLR_CYCLES - 1));
  assign next_state = agree ? state_o :
                      (cond_i ? set_done : !clr_done);
  assign next_cnt = (agree || next_state != state_o) ?
                    '0 : cnt + `PERSIST_CNT_W'(1);

  // state and counter
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= '0;
      state_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      state_o <= next_state;
    end
  end

  // a declaration needs the condition present in the deciding cycle
  a_filter_rise: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    $rose(state_o) |-> $past(cond_i))
    else $error("filter declared without the condition");

  // a clear needs the condition absent in the deciding cycle
  a_filter_fall: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    $fell(state_o) |-> !$past(cond_i))
    else $error("filter cleared with the condition present");

endmodule
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the receive alarm and error interrupt block.
// assumes the register map and field layout of the shared defines header
// and the short persistence counts set below.
`timescale 1ns/1ps
`default_nettype none
`include "t1_alarm_defs.svh"

module testbench;

  // ============================================================
  // clock, reset and design ports
  localparam int unsigned AIS_N = 8;
  localparam int unsigned YEL_N = 12;
  logic clock_i;
  logic arst_n_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic frame_bit_check_i;
  logic frame_bit_error_i;
  logic frame_regained_i;
  logic ais_cond_i;
  logic rai_cond_i;
  logic lcv_i;
  logic oof_state_o;
  logic ais_state_o;
  logic yel_state_o;
  logic irq_o;
  int errors;
  int cmp_count;

  // short persistence counts keep the run to under two hundred cycles
  t1_alarm_error_irq_regs #(
    .AIS_CYCLES(AIS_N),
    .YEL_CYCLES(YEL_N)
  ) t1_alarm_error_irq_regs_i (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .frame_bit_check_i(frame_bit_check_i),
    .frame_bit_error_i(frame_bit_error_i),
    .frame_regained_i(frame_regained_i),
    .ais_cond_i(ais_cond_i),
    .rai_cond_i(rai_cond_i),
    .lcv_i(lcv_i),
    .oof_state_o(oof_state_o),
    .ais_state_o(ais_state_o),
    .yel_state_o(yel_state_o),
    .irq_o(irq_o)
  );

  // 200 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  // ============================================================
  // compare, bus and pulse tasks
  task automatic check8(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check1(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= addr;
    reg_wdata_i <= data;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe was taken
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= addr;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 data = reg_rdata_o;
  endtask

  task automatic read_check(input string name, input logic [7:0] addr,
                            input logic [7:0] exp);
    logic [7:0] d;
    reg_read(addr, d);
    check8(name, exp, d);
  endtask

  task automatic frame_check(input logic err);
    @(posedge clock_i);
    frame_bit_check_i <= 1'b1;
    frame_bit_error_i <= err;
    @(posedge clock_i);
    frame_bit_check_i <= 1'b0;
    frame_bit_error_i <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // ============================================================
  // scenarios
  task automatic test_reset_and_map;
    read_check("status reset", `ADDR_STATUS, 8'h00);
    read_check("enable reset", `ADDR_ENABLE, 8'h00);
    check1("irq after reset", 1'b0, irq_o);
    reg_write(`ADDR_ENABLE, 8'hef);
    read_check("enable reserved bits", `ADDR_ENABLE, 8'h0f);
    reg_write(8'h03, 8'h00);
    read_check("unmapped write ignored", `ADDR_ENABLE, 8'h0f);
    read_check("unmapped read", 8'h03, 8'h00);
    reg_write(`ADDR_ENABLE, 8'h00);
  endtask

  // masked first, then unmasked, then set-beats-read and write-one-clear
  task automatic test_line_code;
    @(posedge clock_i);
    lcv_i <= 1'b1;
    @(posedge clock_i);
    lcv_i <= 1'b0;
    settle(1);
    check1("irq lcv masked", 1'b0, irq_o);
    reg_write(`ADDR_ENABLE, 8'h08);
    settle(1);
    check1("irq lcv enabled", 1'b1, irq_o);
    read_check("lcv flag", `ADDR_STATUS, 8'h08);
    check1("irq after read", 1'b0, irq_o);
    read_check("lcv flag cleared", `ADDR_STATUS, 8'h00);
    // an event in the read cycle must survive for the next read
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= `ADDR_STATUS;
    lcv_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    lcv_i <= 1'b0;
    read_check("event kept over read", `ADDR_STATUS, 8'h08);
    @(posedge clock_i);
    lcv_i <= 1'b1;
    @(posedge clock_i);
    lcv_i <= 1'b0;
    reg_write(`ADDR_STATUS, 8'h08);
    read_check("write one clears", `ADDR_STATUS, 8'h00);
    check1("irq after clear", 1'b0, irq_o);
  endtask

  // tolerance 2 errors within a window of 4 framing bits
  task automatic test_frame_loss;
    reg_write(`ADDR_FRAMING, 8'h42);
    read_check("framing readback", `ADDR_FRAMING, 8'h42);
    reg_write(`ADDR_ENABLE, 8'h04);
    frame_check(1'b1);
    repeat (3) frame_check(1'b0);
    frame_check(1'b1);
    settle(2);
    check1("oof window restart", 1'b0, oof_state_o);
    frame_check(1'b1);
    settle(2);
    check1("oof declared", 1'b1, oof_state_o);
    check1("irq oof enabled", 1'b1, irq_o);
    read_check("oof declare flag", `ADDR_STATUS, 8'h84);
    reg_write(`ADDR_ENABLE, 8'h00);
    @(posedge clock_i);
    frame_regained_i <= 1'b1;
    @(posedge clock_i);
    frame_regained_i <= 1'b0;
    settle(2);
    check1("oof cleared", 1'b0, oof_state_o);
    check1("irq oof masked", 1'b0, irq_o);
    read_check("oof clear flag", `ADDR_STATUS, 8'h04);
    read_check("oof flag gone", `ADDR_STATUS, 8'h00);
    // zero tolerance must never declare, however many errors arrive
    reg_write(`ADDR_FRAMING, 8'h40);
    repeat (3) frame_check(1'b1);
    settle(2);
    check1("oof zero tolerance", 1'b0, oof_state_o);
  endtask

  task automatic test_alarm_indication;
    reg_write(`ADDR_ENABLE, 8'h02);
    @(posedge clock_i);
    ais_cond_i <= 1'b1;
    settle(AIS_N - 2);
    check1("ais early", 1'b0, ais_state_o);
    settle(4);
    check1("ais declared", 1'b1, ais_state_o);
    check1("irq ais enabled", 1'b1, irq_o);
    read_check("ais declare flag", `ADDR_STATUS, 8'h42);
    @(posedge clock_i);
    ais_cond_i <= 1'b0;
    settle(AIS_N - 2);
    check1("ais holds while absent", 1'b1, ais_state_o);
    settle(4);
    check1("ais cleared", 1'b0, ais_state_o);
    read_check("ais clear flag", `ADDR_STATUS, 8'h02);
    check1("irq ais after read", 1'b0, irq_o);
  endtask

  task automatic test_remote_alarm;
    reg_write(`ADDR_ENABLE, 8'h00);
    @(posedge clock_i);
    rai_cond_i <= 1'b1;
    settle(YEL_N - 2);
    check1("yellow early", 1'b0, yel_state_o);
    settle(4);
    check1("yellow declared", 1'b1, yel_state_o);
    check1("irq yellow masked", 1'b0, irq_o);
    reg_write(`ADDR_ENABLE, 8'h01);
    settle(1);
    check1("irq yellow enabled", 1'b1, irq_o);
    read_check("yellow declare flag", `ADDR_STATUS, 8'h21);
    @(posedge clock_i);
    rai_cond_i <= 1'b0;
    settle(3);
    check1("yellow cleared", 1'b0, yel_state_o);
    read_check("yellow clear flag", `ADDR_STATUS, 8'h01);
    check1("irq yellow after read", 1'b0, irq_o);
  endtask

  // ============================================================
  // verdict, watchdog and main sequence
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // the whole sequence needs well under a thousand cycles
  initial begin
    #50000;
    errors++;
    finish_test();
  end

  initial begin
    errors = 0;
    cmp_count = 0;
    arst_n_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    frame_bit_check_i = 1'b0;
    frame_bit_error_i = 1'b0;
    frame_regained_i = 1'b0;
    ais_cond_i = 1'b0;
    rai_cond_i = 1'b0;
    lcv_i = 1'b0;
    repeat (8) @(posedge clock_i);
    arst_n_i <= 1'b1;
    test_reset_and_map();
    test_line_code();
    test_frame_loss();
    test_alarm_indication();
    test_remote_alarm();
    finish_test();
  end

endmodule

`default_nettype wire
